/* hw/isf_pkg.sv */
// Behaviour
// - only maskable sources get flags; reset and software_trap_instruction have none
// - each flag reads 1 while its source requests, 0 otherwise
// - flags 1..20 map to pin, clock_generator, timer_one, timer_two, spi, sci, kbd, adc, tbm, can
// - irq_pending_low holds pending_flags_low_group, flags 6 down to 1 only
// - irq_pending_low bits 1 and 0 always read zero
// - irq_pending_mid holds pending_flags_mid_group, flags 14 down to 7, all bits
// - irq_pending_high holds flags 20 down to 15; bits 7 and 6 read zero
package isf_pkg;

	localparam int ISF_NUM_SRC = 20;
	localparam int ISF_ADDR_W = 8;
	localparam int ISF_DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] ISF_OFS_PEND_LOW = 8'h00;
	localparam logic [7:0] ISF_OFS_PEND_MID = 8'h04;
	localparam logic [7:0] ISF_OFS_PEND_HIGH = 8'h08;
	localparam logic [7:0] ISF_OFS_EVT_STAT = 8'h0c;
	localparam logic [7:0] ISF_OFS_EVT_EN = 8'h10;
	localparam logic [7:0] ISF_OFS_EVT_CLR = 8'h14;

	// field positions of the flag groups
	localparam int ISF_LOW_FIRST = 1;
	localparam int ISF_LOW_LAST = 6;
	localparam int ISF_LOW_SHIFT = 2;
	localparam int ISF_MID_FIRST = 7;
	localparam int ISF_MID_LAST = 14;
	localparam int ISF_HIGH_FIRST = 15;
	localparam int ISF_HIGH_LAST = 20;

	// reset values
	localparam logic [20:1] ISF_RST_FLAGS = 20'h00000;
	localparam logic [31:0] ISF_RST_DATA = 32'h00000000;

endpackage : isf_pkg

/* hw/isf_top.sv */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
module isf_top #(
	parameter int NUM_SRC = isf_pkg::ISF_NUM_SRC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// interrupt request lines, index = flag number
	input wire logic [isf_pkg::ISF_NUM_SRC:1] src_req,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [isf_pkg::ISF_ADDR_W-1:0] paddr,
	input wire logic [isf_pkg::ISF_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [isf_pkg::ISF_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq
);
	import isf_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// register packing is fixed to twenty flags
	if (NUM_SRC != ISF_NUM_SRC) begin : g_bad_num_src
		$error("isf_top: NUM_SRC must be 20");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pending flags

	logic [ISF_NUM_SRC:1] pend_q;
	logic [ISF_NUM_SRC:1] pend_prev_q;
	logic [ISF_NUM_SRC:1] evt_stat_q;
	logic [ISF_NUM_SRC:1] evt_stat_d;
	logic [ISF_NUM_SRC:1] evt_en_q;
	logic [ISF_NUM_SRC:1] evt_rise;
	logic [ISF_NUM_SRC:1] clr_mask;

	// only the twenty maskable sources have a flag; no reset or trap input exists
	// one flop per source, live image of the request
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_q <= ISF_RST_FLAGS;
		end else begin
			pend_q <= src_req;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_prev_q <= ISF_RST_FLAGS;
		end else begin
			pend_prev_q <= pend_q;
		end
	end

	assign evt_rise = pend_q & ~pend_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	logic setup_ph;
	logic wr_take;
	logic pready_q;
	logic pslverr_q;
	logic [ISF_DATA_W-1:0] prdata_q;
	logic [ISF_DATA_W-1:0] rd_data;
	logic rd_err;
	logic [7:0] pend_low_v;
	logic [7:0] pend_mid_v;
	logic [7:0] pend_high_v;

	assign setup_ph = psel && !penable;
	// a write lands only on the access edge that sees pready high
	assign wr_take = psel && penable && pready_q && pwrite;

	// low and mid packed with the top flag at bit 7, high with flag 20 at bit 5
	assign pend_low_v = {pend_q[ISF_LOW_LAST:ISF_LOW_FIRST], 2'b00};
	assign pend_mid_v = pend_q[ISF_MID_LAST:ISF_MID_FIRST];
	assign pend_high_v = {2'b00, pend_q[ISF_HIGH_LAST:ISF_HIGH_FIRST]};

	always_comb begin
		rd_data = ISF_RST_DATA;
		rd_err = 1'b0;
		if (paddr == ISF_OFS_PEND_LOW) begin
			rd_data[7:0] = pend_low_v;
		end else if (paddr == ISF_OFS_PEND_MID) begin
			rd_data[7:0] = pend_mid_v;
		end else if (paddr == ISF_OFS_PEND_HIGH) begin
			rd_data[7:0] = pend_high_v;
		end else if (paddr == ISF_OFS_EVT_STAT) begin
			rd_data[ISF_NUM_SRC-1:0] = evt_stat_q;
		end else if (paddr == ISF_OFS_EVT_EN) begin
			rd_data[ISF_NUM_SRC-1:0] = evt_en_q;
		end else if (paddr == ISF_OFS_EVT_CLR) begin
			rd_data = ISF_RST_DATA;
		end else begin
			rd_err = 1'b1;
		end
	end

	// answer registered in the setup cycle, so every access has zero wait states
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup_ph;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_q <= ISF_RST_DATA;
			pslverr_q <= 1'b0;
		end else if (setup_ph) begin
			prdata_q <= pwrite ? ISF_RST_DATA : rd_data;
			pslverr_q <= rd_err;
		end else begin
			prdata_q <= ISF_RST_DATA;
			pslverr_q <= 1'b0;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////////////
	// event status, enable and clear

	// pending registers have no write path at all
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			evt_en_q <= ISF_RST_FLAGS;
		end else if (wr_take && paddr == ISF_OFS_EVT_EN) begin
			evt_en_q <= pwdata[ISF_NUM_SRC-1:0];
		end
	end

	assign clr_mask = (wr_take && paddr == ISF_OFS_EVT_CLR) ?
		pwdata[ISF_NUM_SRC-1:0] : ISF_RST_FLAGS;

	// a new request in the clearing cycle survives: set wins over clear
	assign evt_stat_d = (evt_stat_q & ~clr_mask) | evt_rise;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			evt_stat_q <= ISF_RST_FLAGS;
		end else begin
			evt_stat_q <= evt_stat_d;
		end
	end

	logic irq_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(evt_stat_d & evt_en_q);
		end
	end

	assign irq = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	property p_pend_follows;
		@(posedge sys_clk) disable iff (!reset_n)
		1'b1 |=> pend_q == $past(src_req);
	endproperty
	a_pend_follows: assert property (p_pend_follows)
		else $error("pending flags do not follow request lines");

	property p_sticky_only_on_rise;
		@(posedge sys_clk) disable iff (!reset_n)
		1'b1 |=> (evt_stat_q & ~$past(evt_stat_q) & ~$past(evt_rise)) == ISF_RST_FLAGS;
	endproperty
	a_sticky_only_on_rise: assert property (p_sticky_only_on_rise)
		else $error("event status set without a source request");

	property p_low_pin_bit;
		@(posedge sys_clk) disable iff (!reset_n)
		(pready_q && !$past(pwrite) && $past(paddr) == ISF_OFS_PEND_LOW)
			|-> prdata_q[2] == $past(src_req[1], 2);
	endproperty
	a_low_pin_bit: assert property (p_low_pin_bit)
		else $error("external pin flag not at low register bit 2");

	property p_low_group;
		@(posedge sys_clk) disable iff (!reset_n)
		(pready_q && !$past(pwrite) && $past(paddr) == ISF_OFS_PEND_LOW)
			|-> prdata_q[7:2] == $past(pend_q[6:1]);
	endproperty
	a_low_group: assert property (p_low_group)
		else $error("low register flags wrong");

	property p_low_zero;
		@(posedge sys_clk) disable iff (!reset_n)
		(pready_q && $past(paddr) == ISF_OFS_PEND_LOW)
			|-> prdata_q[1:0] == 2'b00 && prdata_q[31:8] == 24'h000000;
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("low register reserved bits not zero");

	property p_mid_group;
		@(posedge sys_clk) disable iff (!reset_n)
		(pready_q && !$past(pwrite) && $past(paddr) == ISF_OFS_PEND_MID)
			|-> prdata_q[7:0] == $past(pend_q[14:7]);
	endproperty
	a_mid_group: assert property (p_mid_group)
		else $error("mid register flags wrong");

	property p_high_group;
		@(posedge sys_clk) disable iff (!reset_n)
		(pready_q && !$past(pwrite) && $past(paddr) == ISF_OFS_PEND_HIGH)
			|-> prdata_q[7:0] == {2'b00, $past(pend_q[20:15])};
	endproperty
	a_high_group: assert property (p_high_group)
		else $error("high register flags or zero bits wrong");

	// the error flag stands with pready, so it is looked at on the access edge itself
	property p_pend_write_ignored;
		@(posedge sys_clk) disable iff (!reset_n)
		(wr_take && (paddr == ISF_OFS_PEND_LOW || paddr == ISF_OFS_PEND_MID
			|| paddr == ISF_OFS_PEND_HIGH))
			|-> !pslverr_q ##1 ($stable(evt_en_q) && pend_q == $past(src_req));
	endproperty
	a_pend_write_ignored: assert property (p_pend_write_ignored)
		else $error("write to a pending register had an effect");

	property p_irq_level;
		@(posedge sys_clk) disable iff (!reset_n)
		1'b1 |=> irq_q == |(evt_stat_q & $past(evt_en_q));
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt output disagrees with status and enable");

	property p_set_beats_clear;
		@(posedge sys_clk) disable iff (!reset_n)
		(evt_rise != ISF_RST_FLAGS) |=> (evt_stat_q & $past(evt_rise)) == $past(evt_rise);
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear)
		else $error("event lost in clearing cycle");

	property p_evt_clear;
		@(posedge sys_clk) disable iff (!reset_n)
		(wr_take && paddr == ISF_OFS_EVT_CLR)
			|=> (evt_stat_q & $past(pwdata[ISF_NUM_SRC-1:0])
				& ~$past(evt_rise)) == ISF_RST_FLAGS;
	endproperty
	a_evt_clear: assert property (p_evt_clear)
		else $error("write-one-to-clear left an event status bit set");

	property p_en_write;
		@(posedge sys_clk) disable iff (!reset_n)
		(wr_take && paddr == ISF_OFS_EVT_EN)
			|=> evt_en_q == $past(pwdata[ISF_NUM_SRC-1:0]);
	endproperty
	a_en_write: assert property (p_en_write)
		else $error("enable register did not take the written value");

	property p_stat_read;
		@(posedge sys_clk) disable iff (!reset_n)
		(pready_q && !$past(pwrite) && $past(paddr) == ISF_OFS_EVT_STAT)
			|-> prdata_q[ISF_NUM_SRC-1:0] == $past(evt_stat_q);
	endproperty
	a_stat_read: assert property (p_stat_read)
		else $error("event status read back wrong");

	// bus answer: one cycle, no data on writes, error on offsets past the map
	property p_pready_one;
		@(posedge sys_clk) disable iff (!reset_n)
		pready_q |=> !pready_q;
	endproperty
	a_pready_one: assert property (p_pready_one)
		else $error("pready held longer than one cycle");

	property p_unmapped_err;
		@(posedge sys_clk) disable iff (!reset_n)
		(setup_ph && paddr > ISF_OFS_EVT_CLR)
			|=> pready_q && pslverr_q && prdata_q == ISF_RST_DATA;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access not answered with an error");

	property p_write_no_data;
		@(posedge sys_clk) disable iff (!reset_n)
		(pready_q && $past(pwrite)) |-> prdata_q == ISF_RST_DATA;
	endproperty
	a_write_no_data: assert property (p_write_no_data)
		else $error("read data driven during a write");

	c_read_low: cover property (@(posedge sys_clk) disable iff (!reset_n)
		pready_q && $past(paddr) == ISF_OFS_PEND_LOW && prdata_q[7:2] != 6'h00);
	c_irq_raise: cover property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(irq_q));
	c_clear_race: cover property (@(posedge sys_clk) disable iff (!reset_n)
		(clr_mask & evt_rise) != ISF_RST_FLAGS);
	c_unmapped: cover property (@(posedge sys_clk) disable iff (!reset_n)
		pready_q && pslverr_q);
	c_en_write: cover property (@(posedge sys_clk) disable iff (!reset_n)
		wr_take && paddr == ISF_OFS_EVT_EN);

endmodule : isf_top

/* verification/isf_src_model.sv */
`timescale 1ns/1ns
// stands in for the peripherals: request levels change only at the clock edge
module isf_src_model (
	// clock
	input wire logic sys_clk,
	// request pattern wanted by the bench
	input wire logic [20:1] want,
	// request lines to the block
	output logic [20:1] src_req
);
	always_ff @(posedge sys_clk) begin
		src_req <= want;
	end
endmodule : isf_src_model

/* verification/interrupt_status_flags_tb.sv */
`timescale 1ns/1ns
module interrupt_status_flags_tb;
	import isf_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [20:1] want = 20'h00000;
	logic [20:1] src_req;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int check_count = 0;
	logic [7:0] ofs [3] = '{ISF_OFS_PEND_LOW, ISF_OFS_PEND_MID, ISF_OFS_PEND_HIGH};

	always #4 sys_clk = ~sys_clk;

	isf_src_model i_src (.sys_clk(sys_clk), .want(want), .src_req(src_req));
	isf_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .src_req(src_req), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one idle edge first, so a release and the next setup never share a time step
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h00000000);
		check(what, rd, exp);
		check("pslverr", {31'h0, err}, {31'h0, e});
	endtask : rchk

	function automatic logic [31:0] pend(input int r, input logic [20:1] f);
		if (r == 0) return {24'h000000, f[6:1], 2'b00};
		if (r == 1) return {24'h000000, f[14:7]};
		return {24'h000000, 2'b00, f[20:15]};
	endfunction : pend

	task automatic settle(input logic [20:1] w);
		want <= w;
		repeat (5) @(posedge sys_clk);
	endtask : settle

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_walk();
		logic [20:1] w;
		for (int k = 0; k <= 21; k++) begin
			w = (k == 21) ? 20'hfffff : (k == 0) ? 20'h00000 : 20'h00001 << (k - 1);
			settle(w);
			for (int r = 0; r < 3; r++) rchk("pending", ofs[r], pend(r, w), 1'b0);
		end
	endtask : t_walk

	task automatic t_write();
		settle(20'h5a5a5);
		for (int r = 0; r < 3; r++) begin
			apb(1'b1, ofs[r], 32'hffffffff);
			check("write err", {31'h0, err}, 32'h0);
			rchk("after write", ofs[r], pend(r, 20'h5a5a5), 1'b0);
		end
		rchk("unmapped", 8'h40, 32'h00000000, 1'b1);
	endtask : t_write

	task automatic t_irq();
		settle(20'h00000);
		apb(1'b1, ISF_OFS_EVT_CLR, 32'h000fffff);
		apb(1'b1, ISF_OFS_EVT_EN, 32'h00000010);
		rchk("enable", ISF_OFS_EVT_EN, 32'h00000010, 1'b0);
		settle(20'h00020);
		check("masked irq", {31'h0, irq}, 32'h0);
		settle(20'h00010);
		check("irq", {31'h0, irq}, 32'h1);
		settle(20'h00000);
		rchk("event", ISF_OFS_EVT_STAT, 32'h00000030, 1'b0);
		check("sticky irq", {31'h0, irq}, 32'h1);
		apb(1'b1, ISF_OFS_EVT_CLR, 32'h00000010);
		repeat (3) @(posedge sys_clk);
		check("cleared irq", {31'h0, irq}, 32'h0);
	endtask : t_irq

	// flag 9 rises again on the very edge that clears its event: the set must win
	task automatic t_race();
		settle(20'h00100);
		settle(20'h00000);
		want <= 20'h00100;
		apb(1'b1, ISF_OFS_EVT_CLR, 32'h00000100);
		rchk("set over clear", ISF_OFS_EVT_STAT, 32'h00000120, 1'b0);
		apb(1'b1, ISF_OFS_EVT_STAT, 32'h00000000);
		check("status write err", {31'h0, err}, 32'h0);
		rchk("status read only", ISF_OFS_EVT_STAT, 32'h00000120, 1'b0);
		rchk("clear reads zero", ISF_OFS_EVT_CLR, 32'h00000000, 1'b0);
	endtask : t_race

	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim

	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int r = 0; r < 3; r++) rchk("reset", ofs[r], 32'h00000000, 1'b0);
		t_walk();
		t_write();
		t_irq();
		t_race();
		end_sim();
	end

	// whole run needs well under 2000 edges
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		end_sim();
	end
endmodule : interrupt_status_flags_tb
